// [dv/lpmc_core_model.sv]
`timescale 1ns/1ps
// Core stand-in: each wakeup pulse is one serviced interrupt exception
module lpmc_core_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       core_wake_irq,
   output logic      [7:0] svc_cnt
);
   logic wake_q;
   // Vector on the rising pulse only, so a held line is still one exception
   always_ff @(posedge clk) begin
      wake_q <= core_wake_irq;
      if (srst) svc_cnt <= 8'h00;
      else if (core_wake_irq && !wake_q) svc_cnt <= svc_cnt + 8'h01;
   end
endmodule : lpmc_core_model

// [dv/lpmc_ctrl_asserts.sv]
`timescale 1ns/1ps
// Port-level checks on the low-power controller
module lpmc_ctrl_asserts import lpmc_pkg::*; (
   input wire logic                 clk,
   input wire logic                 srst,
   input wire logic                 lp_ins_valid,
   input wire logic                 fast_irq_req,
   input wire logic                 norm_irq_req,
   input wire logic                 fast_irq_enable,
   input wire logic                 irq_enable_bit,
   input wire logic                 exception_enable_bit,
   input wire logic                 rst_logic_req,
   input wire logic                 clk_mod_rst_req,
   input wire logic                 wdog_rst_req,
   input wire logic                 wdog_running,
   input wire logic                 adc_irq,
   input wire logic                 edge_level_irq,
   input wire logic                 debug_port_req,
   input wire logic                 debug_request_pin_n,
   input wire logic                 core_wake_irq,
   input wire logic                 sys_reset_wake,
   input wire logic                 flash_clk_en,
   input wire logic                 edge_level_only,
   input wire logic [1:0]           lp_ins_code,
   input wire logic [LPMC_NPER-1:0] periph_disable,
   input wire logic [LPMC_NPER-1:0] periph_clk_en,
   input wire logic [5:0]           lp_state
);
   logic       quiet;
   logic [4:0] fw_q;
   // No reset or debug request pending, so no higher-priority exit can win
   assign quiet = !rst_logic_req && !clk_mod_rst_req && !wdog_rst_req && !debug_port_req
                  && debug_request_pin_n;
   // Consecutive cycles spent in flash recovery
   always_ff @(posedge clk) begin
      if (srst || lp_state != LPMC_FWAKE) fw_q <= 5'h00;
      else fw_q <= fw_q + 5'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_INS_TAKE: assert property (lp_state == LPMC_RUN && lp_ins_valid && lp_ins_code != 2'h0
      && quiet |=> lp_state == (6'h01 << $past(lp_ins_code))) else $error("mode entry missed");
   AST_STOP_GATE: assert property (lp_state == LPMC_STOP && $past(lp_state) == LPMC_STOP
      |-> periph_clk_en[9:0] == 10'h000 && edge_level_only) else $error("stop gating wrong");
   AST_DISABLE: assert property (!$past(srst) && !$past(srst, 2) && $stable(periph_disable)
      && $past(periph_disable, 2) == periph_disable |-> (periph_clk_en & periph_disable) == 11'h000)
      else $error("disabled unit clocked");
   AST_FWAKE: assert property (lp_state == LPMC_FWAKE |-> flash_clk_en
      && !periph_clk_en[LPMC_P_CORE]) else $error("flash recovery clocks wrong");
   AST_FWAKE_LEN: assert property ($past(lp_state) == LPMC_FWAKE && lp_state == LPMC_RUN
      |-> fw_q == 5'h10) else $error("flash recovery length wrong");
   AST_IRQ_WAKE: assert property (lp_state inside {LPMC_WAIT, LPMC_DOZE} && norm_irq_req
      && adc_irq && irq_enable_bit && exception_enable_bit && quiet
      |=> lp_state == LPMC_RUN && core_wake_irq) else $error("irq wake missed");
   AST_NO_WAKE: assert property (lp_state inside {LPMC_WAIT, LPMC_DOZE} && quiet
      && !(fast_irq_req && fast_irq_enable) && !(irq_enable_bit && exception_enable_bit)
      |=> lp_state == $past(lp_state)) else $error("unqualified wake");
   AST_RST_WAKE: assert property (lp_state == LPMC_DOZE && wdog_rst_req && wdog_running
      && !debug_port_req && debug_request_pin_n
      |=> sys_reset_wake && !core_wake_irq && lp_state == LPMC_RUN) else $error("reset wake");
   AST_DBG: assert property (lp_state inside {LPMC_WAIT, LPMC_DOZE, LPMC_STOP}
      && debug_port_req |=> lp_state == LPMC_DEBUG) else $error("debug entry missed");
   AST_STOP_HOLD: assert property (lp_state == LPMC_STOP && !edge_level_irq && quiet
      |=> lp_state == LPMC_STOP) else $error("stop left without cause");
endmodule : lpmc_ctrl_asserts
bind lpmc_ctrl lpmc_ctrl_asserts u_lpmc_chk (.*);

// [dv/tb_low_power_mode_control.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_low_power_mode_control import lpmc_pkg::*;;
   logic clk = 0, srst = 1, lp_ins_valid = 0, fast_irq_req = 0, norm_irq_req = 0;
   logic fast_irq_enable = 0, irq_enable_bit = 0, exception_enable_bit = 0;
   logic rst_logic_req = 0, clk_mod_rst_req = 0, wdog_rst_req = 0, wdog_running = 0;
   logic edge_irq = 0, edge_level_irq = 0, adc_irq = 0, pit_irq = 0, spi_irq = 0;
   logic sci_irq = 0, tim_irq = 0, wdog_run_wait = 0, wdog_run_doze = 0, pit_run_doze = 0;
   logic spi_run_doze = 0, sci_run_doze = 0, clk_run_stop = 0, debug_port_req = 0;
   logic debug_request_pin_n = 1, debug_exit = 0, core_wake_irq, core_wake_fast;
   logic flash_clk_en, edge_level_only, sys_reset_wake;
   logic [1:0]           lp_ins_code = 2'h0;
   logic [LPMC_NPER-1:0] periph_disable = 11'h000, periph_clk_en;
   logic [5:0]           lp_state;
   logic [7:0]           svc_cnt;
   int                   mismatches = 0, checks = 0, k;
   lpmc_ctrl DUT (.*);
   lpmc_core_model u_core (.*);
   // System clock, 8 ns period
   always #4 clk = ~clk;
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Expected gates per mode; disables override whatever the mode allows
   function automatic logic [LPMC_NPER-1:0] mode_en(input logic [5:0] s);
      logic [LPMC_NPER-1:0] e;
      e = 11'h7f8;
      if (s == LPMC_WAIT) e[LPMC_P_WDOG] = wdog_run_wait;
      if (s == LPMC_DOZE) begin
         e[LPMC_P_WDOG] = wdog_run_doze;
         e[LPMC_P_PIT] = pit_run_doze;
         e[LPMC_P_SPI] = spi_run_doze;
         e[LPMC_P_SCI] = sci_run_doze;
      end
      if (s == LPMC_STOP) e = {clk_run_stop, 10'h000};
      return e & ~periph_disable;
   endfunction : mode_en
   // Bounded wait for the mode to move off its present value
   task automatic wait_move(input logic [5:0] s);
      logic [5:0] p;
      p = lp_state;
      for (int i = 0; i < 8 && lp_state === p; i++) tick();
      `CHK("lp_state", s, lp_state)
   endtask : wait_move
   // Valid stays up only until the mode has moved, so it is taken on_chip_debug_port
   task automatic enter(input logic [1:0] c, input logic [5:0] s);
      lp_ins_code = c;
      lp_ins_valid = 1;
      wait_move(s);
      lp_ins_valid = 0;
      tick(2);
      `CHK("periph_clk_en", mode_en(s), periph_clk_en)
   endtask : enter
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // Hang guard, far beyond the roughly 140 cycles the sequence needs
   initial begin
      #50000;
      mismatches++;
      print_verdict();
   end
   initial begin
      tick(20);
      srst = 0;
      tick(6);
      `CHK("lp_state", LPMC_RUN, lp_state)
      `CHK("periph_clk_en", LPMC_ALL_ON, periph_clk_en)
      // Valid with code zero is no instruction and must be ignored
      lp_ins_valid = 1'b1;
      tick(2);
      lp_ins_valid = 1'b0;
      tick();
      `CHK("code zero", LPMC_RUN, lp_state)
      periph_disable = 11'h020;
      wdog_run_wait = 1;
      irq_enable_bit = 1;
      // Every interrupt source wakes wait on_chip_debug_port fully qualified
      for (int i = 0; i < 6; i++) begin
         enter(LPMC_INS_WAIT, LPMC_WAIT);
         {edge_irq, adc_irq, pit_irq, spi_irq, sci_irq, tim_irq} = 6'h01 << i;
         norm_irq_req = 1;
         tick(4);
         `CHK("no ee", LPMC_WAIT, lp_state)
         exception_enable_bit = 1;
         wait_move(LPMC_RUN);
         `CHK("core_wake_irq", 1'b1, core_wake_irq)
         {edge_irq, adc_irq, pit_irq, spi_irq, sci_irq, tim_irq} = 6'h00;
         norm_irq_req = 0;
         exception_enable_bit = 0;
      end
      pit_run_doze = 1;
      sci_run_doze = 1;
      enter(LPMC_INS_DOZE, LPMC_DOZE);
      tim_irq = 1;
      fast_irq_req = 1;
      tick(4);
      `CHK("no fe", LPMC_DOZE, lp_state)
      fast_irq_enable = 1;
      wait_move(LPMC_RUN);
      `CHK("core_wake_fast", 1'b1, core_wake_fast)
      tim_irq = 0;
      fast_irq_req = 0;
      wdog_running = 1;
      exception_enable_bit = 1;
      // Each reset source, with a qualified irq raised at the same edge
      for (int i = 0; i < 3; i++) begin
         enter(LPMC_INS_DOZE, LPMC_DOZE);
         adc_irq = 1;
         norm_irq_req = 1;
         {rst_logic_req, clk_mod_rst_req, wdog_rst_req} = 3'h1 << i;
         wait_move(LPMC_RUN);
         `CHK("sys_reset_wake", 1'b1, sys_reset_wake)
         `CHK("irq on reset", 1'b0, core_wake_irq)
         {rst_logic_req, clk_mod_rst_req, wdog_rst_req} = 3'h0;
         adc_irq = 0;
         norm_irq_req = 0;
      end
      clk_run_stop = 1;
      enter(LPMC_INS_STOP, LPMC_STOP);
      `CHK("edge_level_only", 1'b1, edge_level_only)
      adc_irq = 1;
      norm_irq_req = 1;
      tick(4);
      `CHK("adc in stop", LPMC_STOP, lp_state)
      adc_irq = 0;
      edge_level_irq = 1;
      wait_move(LPMC_FWAKE);
      `CHK("flash_clk_en", 1'b1, flash_clk_en)
      for (k = 0; k < 40 && lp_state === LPMC_FWAKE; k++) tick();
      `CHK("fwake cycles", 16, k)
      edge_level_irq = 0;
      norm_irq_req = 0;
      spi_run_doze = 1;
      enter(LPMC_INS_DOZE, LPMC_DOZE);
      debug_port_req = 1;
      wait_move(LPMC_DEBUG);
      periph_disable = 11'h060;
      debug_port_req = 0;
      debug_exit = 1;
      wait_move(LPMC_DOZE);
      debug_exit = 0;
      tick(2);
      `CHK("kept change", mode_en(LPMC_DOZE), periph_clk_en)
      debug_request_pin_n = 0;
      wait_move(LPMC_DEBUG);
      debug_request_pin_n = 1;
      tick(4);
      debug_exit = 1;
      wait_move(LPMC_DOZE);
      debug_exit = 0;
      `CHK("svc_cnt", 8'h08, svc_cnt)
      print_verdict();
   end
endmodule : tb_low_power_mode_control

// [verilog/lpmc_ctrl.sv]
`timescale 1ns/1ps
// Low-power mode controller: sequences run, wait, doze, stop and debug
module lpmc_ctrl import lpmc_pkg::*; (
   input  wire logic                 clk,
   input  wire logic                 srst,
   // Core side
   input  wire logic                 lp_ins_valid,
   input  wire logic [1:0]           lp_ins_code,
   input  wire logic                 fast_irq_req,
   input  wire logic                 norm_irq_req,
   input  wire logic                 fast_irq_enable,
   input  wire logic                 irq_enable_bit,
   input  wire logic                 exception_enable_bit,
   output logic                      core_wake_irq,
   output logic                      core_wake_fast,
   // Reset sources
   input  wire logic                 rst_logic_req,
   input  wire logic                 clk_mod_rst_req,
   input  wire logic                 wdog_rst_req,
   input  wire logic                 wdog_running,
   // Peripheral interrupt sources (edge, adc, pit, spi, sci, tim)
   input  wire logic                 edge_irq,
   input  wire logic                 edge_level_irq,
   input  wire logic                 adc_irq,
   input  wire logic                 pit_irq,
   input  wire logic                 spi_irq,
   input  wire logic                 sci_irq,
   input  wire logic                 tim_irq,
   // Per-peripheral software disables and programmable-mode bits
   input  wire logic [LPMC_NPER-1:0] periph_disable,
   input  wire logic                 wdog_run_wait,
   input  wire logic                 wdog_run_doze,
   input  wire logic                 pit_run_doze,
   input  wire logic                 spi_run_doze,
   input  wire logic                 sci_run_doze,
   input  wire logic                 clk_run_stop,
   // Debug entry: port request already clean from the test clock domain; pin synchronised here
   input  wire logic                 debug_port_req,
   input  wire logic                 debug_request_pin_n,
   input  wire logic                 debug_exit,
   // Outputs to peripheral clock gates, plus reset-wake flag and mode
   output logic [LPMC_NPER-1:0]      periph_clk_en,
   output logic                      flash_clk_en,
   output logic                      edge_level_only,
   output logic                      sys_reset_wake,
   output logic [5:0]                lp_state
);
   lpmc_state_t state_q;
   lpmc_state_t state_d;
   lpmc_state_t saved_q;
   logic [4:0]  fcnt_q;
   logic        dbg_pin_raw;
   logic        dbg_pin_act;
   logic        dbg_req;
   logic        rst_wake;
   logic        irq_wake;
   logic        fast_ok;
   logic        norm_ok;
   logic        stop_m;
   logic        doze_m;
   logic        wait_m;
   logic [LPMC_NPER-1:0] en_d;
   logic [LPMC_NPER-1:0] en_q;
   logic        wake_irq_q;
   logic        wake_fast_q;
   logic        rst_wake_q;

   // Inverted ahead of the chain so its reset value is the pin's idle level;
   // a low reset value on the raw pin would read as a debug request after reset
   assign dbg_pin_raw = ~debug_request_pin_n;

   // Debug pin comes from outside; debug port request was crossed in its own domain
   lpmc_sync #(.W(1)) u_dbg_sync (
      .clk  (clk),
      .srst (srst),
      .din  (dbg_pin_raw),
      .dout (dbg_pin_act)
   );

   // Debug port runs on test clock elsewhere; only its entry request lands here
   assign dbg_req = debug_port_req | dbg_pin_act;

   assign stop_m = (state_q == LPMC_STOP);
   assign doze_m = (state_q == LPMC_DOZE);
   assign wait_m = (state_q == LPMC_WAIT);

   // Reset wakeup; watchdog counts only while running and not frozen in stop
   assign rst_wake = rst_logic_req | clk_mod_rst_req
                   | (wdog_rst_req & wdog_running & ~stop_m);

   // Interrupt wakeup qualified by status-word enables
   assign fast_ok = fast_irq_req & fast_irq_enable;
   assign norm_ok = norm_irq_req & irq_enable_bit & exception_enable_bit;

   // In stop only level-detected edge port interrupts reach the core
   assign irq_wake = (fast_ok | norm_ok)
                   & (stop_m ? edge_level_irq
                             : (edge_irq | adc_irq | pit_irq | spi_irq | sci_irq
                                | tim_irq));

   // Mode sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LPMC_RUN: begin
            if (dbg_req) begin
               state_d = LPMC_DEBUG;
            end else if (lp_ins_valid) begin
               unique case (lp_ins_code)
                  LPMC_INS_WAIT: state_d = LPMC_WAIT;
                  LPMC_INS_DOZE: state_d = LPMC_DOZE;
                  LPMC_INS_STOP: state_d = LPMC_STOP;
                  default:       state_d = LPMC_RUN; // Code zero is no instruction
               endcase
            end
         end
         LPMC_WAIT, LPMC_DOZE: begin
            if (dbg_req) begin
               state_d = LPMC_DEBUG;
            end else if (rst_wake || irq_wake) begin
               state_d = LPMC_RUN;
            end
         end
         LPMC_STOP: begin
            if (dbg_req) begin
               state_d = LPMC_DEBUG;
            end else if (rst_wake || irq_wake) begin
               state_d = LPMC_FWAKE;
            end
         end
         LPMC_FWAKE: begin
            if (fcnt_q == LPMC_FLASH_WAKE_CYC - 5'h01) begin
               state_d = LPMC_RUN;
            end
         end
         LPMC_DEBUG: begin
            if (debug_exit && !dbg_req) begin
               state_d = saved_q;
            end
         end
         default: state_d = LPMC_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= LPMC_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Mode held across debug; peripheral settings are untouched so changes stay
   always_ff @(posedge clk) begin
      if (srst) begin
         saved_q <= LPMC_RUN;
      end else if (state_d == LPMC_DEBUG && state_q != LPMC_DEBUG) begin
         saved_q <= (state_q == LPMC_FWAKE) ? LPMC_RUN : state_q;
      end
   end

   // Flash recovery counter
   always_ff @(posedge clk) begin
      if (srst) begin
         fcnt_q <= '0;
      end else if (state_q == LPMC_FWAKE) begin
         fcnt_q <= fcnt_q + 5'h01;
      end else begin
         fcnt_q <= '0;
      end
   end

   // Peripheral enable table per mode
   always_comb begin
      en_d = LPMC_ALL_ON;
      unique case (state_q)
         LPMC_RUN, LPMC_DEBUG: begin
            en_d = LPMC_ALL_ON;
         end
         LPMC_WAIT: begin
            en_d[LPMC_P_CORE]  = 1'b0;
            en_d[LPMC_P_RAM]   = 1'b0;
            en_d[LPMC_P_FLASH] = 1'b0;
            en_d[LPMC_P_WDOG]  = wdog_run_wait;
         end
         LPMC_DOZE: begin
            en_d[LPMC_P_CORE]  = 1'b0;
            en_d[LPMC_P_RAM]   = 1'b0;
            en_d[LPMC_P_FLASH] = 1'b0;
            en_d[LPMC_P_WDOG]  = wdog_run_doze;
            en_d[LPMC_P_PIT]   = pit_run_doze;
            en_d[LPMC_P_SPI]   = spi_run_doze;
            en_d[LPMC_P_SCI]   = sci_run_doze;
         end
         LPMC_STOP, LPMC_FWAKE: begin
            en_d = '0;
            en_d[LPMC_P_CLK] = clk_run_stop;
            // Registered flash enable bridges the cycle in which recovery ends
            en_d[LPMC_P_FLASH] = (state_q == LPMC_FWAKE);
         end
         default: en_d = LPMC_ALL_ON;
      endcase
      en_d = en_d & ~periph_disable;
   end

   // Registered outputs; the core gates its own idle units per cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q        <= LPMC_ALL_ON;
         wake_irq_q  <= 1'b0;
         wake_fast_q <= 1'b0;
         rst_wake_q  <= 1'b0;
      end else begin
         en_q        <= en_d;
         wake_irq_q  <= (wait_m || doze_m || stop_m) && !dbg_req && !rst_wake
                        && irq_wake;
         wake_fast_q <= fast_ok;
         rst_wake_q  <= (wait_m || doze_m || stop_m) && rst_wake;
      end
   end

   assign periph_clk_en   = en_q;
   assign flash_clk_en    = en_q[LPMC_P_FLASH] | (state_q == LPMC_FWAKE);
   assign edge_level_only = ~en_q[LPMC_P_EDGE];
   assign core_wake_irq   = wake_irq_q;
   assign core_wake_fast  = wake_fast_q & wake_irq_q;
   assign sys_reset_wake  = rst_wake_q;
   assign lp_state        = state_q;
endmodule : lpmc_ctrl

// [verilog/lpmc_pkg.sv]
package lpmc_pkg;
   // Peripheral index positions in the enable vectors
   localparam int unsigned LPMC_P_CORE  = 0;
   localparam int unsigned LPMC_P_RAM   = 1;
   localparam int unsigned LPMC_P_FLASH = 2;
   localparam int unsigned LPMC_P_EDGE  = 3;
   localparam int unsigned LPMC_P_ADC   = 4;
   localparam int unsigned LPMC_P_WDOG  = 5;
   localparam int unsigned LPMC_P_PIT   = 6;
   localparam int unsigned LPMC_P_SPI   = 7;
   localparam int unsigned LPMC_P_SCI   = 8;
   localparam int unsigned LPMC_P_TIM   = 9;
   localparam int unsigned LPMC_P_CLK   = 10;
   localparam int unsigned LPMC_NPER    = 11;

   // Instruction codes presented on the mode request port
   localparam logic [1:0] LPMC_INS_WAIT = 2'h1;
   localparam logic [1:0] LPMC_INS_DOZE = 2'h2;
   localparam logic [1:0] LPMC_INS_STOP = 2'h3;

   // Flash recovery clocks before system clocks return from stop
   localparam logic [4:0] LPMC_FLASH_WAKE_CYC = 5'h10;

   localparam logic [LPMC_NPER-1:0] LPMC_ALL_ON = 11'h7ff;

   typedef enum logic [5:0] {
      LPMC_RUN   = 6'h01,
      LPMC_WAIT  = 6'h02,
      LPMC_DOZE  = 6'h04,
      LPMC_STOP  = 6'h08,
      LPMC_FWAKE = 6'h10,
      LPMC_DEBUG = 6'h20
   } lpmc_state_t;
endpackage : lpmc_pkg

// [verilog/lpmc_sync.sv]
`timescale 1ns/1ps
// Three-stage synchroniser: a change counts when stages two and three agree
module lpmc_sync import lpmc_pkg::*; #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] dout_q;

   // Chain; stage one feeds stage two only
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         dout_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               dout_q[i] <= s3_q[i]; // Filters one-cycle glitches
            end
         end
      end
   end

   assign dout = dout_q;
endmodule : lpmc_sync
